//--- pkg/dram_pd_cfg.svh
// Offsets, field positions, reset values and timing counts of the rank power-down block
`ifndef DRAM_PD_CFG_SVH
`define DRAM_PD_CFG_SVH
`define PDC_RANKS            4
`define PDC_IDLE_W           12
`define PDC_EXIT_W           8
`define PDC_TYPE_MSB         15
`define PDC_TYPE_LSB         12
`define PDC_IDLE_MSB         11
`define PDC_IDLE_LSB         0
`define PDC_TYPE_NONE        4'h0
`define PDC_TYPE_ACTIVE      4'h2
`define PDC_TYPE_PRECHARGED_DLL_OFF_SLEEP 4'h6
`define PDC_CONFIG_RESET     16'h0000
`define PDC_PRESENT_RESET    4'hf
`define PDC_ADR_CONFIG       8'h00
`define PDC_ADR_CONTROL      8'h04
`define PDC_ADR_PRESENT      8'h08
`define PDC_ADR_STATUS       8'h0c
`define PDC_CTL_CKE_EN       0
`define PDC_CTL_TRI_EN       1
`define PDC_CTL_LOCK         2
`define PDC_TXP_CYCLES       4
`define PDC_TXPDLL_CYCLES    20
`endif

//--- pkg/dram_pd_pkg.sv
// Types shared by the rank power-down block and its register slave
`include "dram_pd_cfg.svh"
package dram_pd_pkg;
  typedef enum logic [2:0] {RANK_OFF, RANK_AWAKE, RANK_CLOSING, RANK_ASLEEP, RANK_EXIT}
    rank_state_t;

  typedef struct packed {
    rank_state_t               state;
    logic [`PDC_IDLE_W-1:0]    idle;
    logic [`PDC_EXIT_W-1:0]    exit_cnt;
    logic                      woke_txn;
    logic                      dll_off;
    logic                      cke;
    logic                      precharge_req;
    logic                      cmd_ready;
    logic                      data_ready;
  } rank_t;

  typedef struct packed {
    rank_t [`PDC_RANKS-1:0]    ranks;
    logic                      refresh_pending;
    logic                      refresh_ready;
    logic [`PDC_RANKS-1:0]     drive_oe;
    logic [`PDC_RANKS-1:0]     deep_sleep;
  } pd_state_t;

  typedef struct packed {
    logic [15:0]               config_word;
    logic                      cke_en;
    logic                      tri_en;
    logic                      lock;
    logic [`PDC_RANKS-1:0]     present;
    logic                      ack;
    logic [31:0]               rdata;
  } regs_t;
endpackage

//--- tb/dram_pd_props.sv
// Port assertions for the rank clock-enable power-down block
module dram_pd_props #(
  parameter int unsigned TXP_CYCLES = 4
)
(
  // Watched ports
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic [3:0] pages_open_i,
  input wire logic [3:0] cmd_ready_o,
  input wire logic [3:0] data_ready_o,
  input wire logic [3:0] dll_off_o,
  input wire logic       refresh_ready_o,
  input wire logic [3:0] cke_o,
  input wire logic [3:0] cke_oe_o,
  input wire logic [3:0] cs_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  chk_cke_reset: assert property (rst_i |=> cke_o == 4'h0)
    else $error("clock enable high after reset");
  chk_oe_reset: assert property (rst_i |=> (cke_oe_o & cs_oe_o) == 4'hf)
    else $error("pin enable low after reset");
  chk_oe_pair: assert property (disable iff (rst_i) cke_oe_o == cs_oe_o)
    else $error("select and clock enable drivers differ");
  chk_ack_once: assert property (disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  chk_ack_cause: assert property (disable iff (rst_i) wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_data_cmd: assert property (disable iff (rst_i) (data_ready_o & ~cmd_ready_o) == 4'h0)
    else $error("data allowed before commands");
  chk_cmd_cke: assert property (disable iff (rst_i) (cmd_ready_o & ~cke_o) == 4'h0)
    else $error("commands allowed with clock enable low");
  chk_dll_cke: assert property (disable iff (rst_i) (dll_off_o & cke_o) == 4'h0)
    else $error("DLL off while clock enable high");
  chk_cmd_delay: assert property (disable iff (rst_i)
    $rose(cmd_ready_o[0]) |-> $past(cke_o[0], TXP_CYCLES))
    else $error("exit delay too short");
  chk_pages_closed: assert property (disable iff (rst_i)
    $rose(dll_off_o[0]) |-> !$past(pages_open_i[0]))
    else $error("deep sleep with pages open");
  chk_refresh_up: assert property (disable iff (rst_i) refresh_ready_o |-> dll_off_o == 4'h0)
    else $error("refresh ready with rank asleep");
  cover property (dll_off_o[0]);
  cover property (refresh_ready_o);
  cover property ($rose(cmd_ready_o[0]));
endmodule // dram_pd_props

bind dram_rank_cke_powerdown dram_pd_props #(.TXP_CYCLES(TXP_CYCLES)) dram_pd_props_i (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pages_open_i, .cmd_ready_o,
  .data_ready_o, .dll_off_o, .refresh_ready_o, .cke_o, .cke_oe_o, .cs_oe_o);

//--- tb/dram_rank_cke_powerdown_tb.sv
// Self-checking bench for the rank clock-enable power-down block
module dram_rank_cke_powerdown_tb import dram_pd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 8;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc = 0, stb = 0, we = 0, rreq = 0, rdone = 0, rready, ack;
  logic [7:0]  adr = 0;
  logic [31:0] dat = 0, rd, q;
  logic [3:0]  arrive = 0, queued = 0, pages, cke, cke_oe, cs_oe, pre, cmd, dready, dll;
  int          errors = 0, num_checks = 0, n;

  initial forever #2 clk_i = ~clk_i;

  dram_rank_cke_powerdown #(.TXP_CYCLES(2), .TXPDLL_CYCLES(4)) dram_rank_cke_powerdown_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .txn_arrive_i(arrive), .txn_queued_i(queued), .pages_open_i(pages),
    .precharge_req_o(pre), .cmd_ready_o(cmd), .data_ready_o(dready), .dll_off_o(dll),
    .refresh_req_i(rreq), .refresh_done_i(rdone), .refresh_ready_o(rready),
    .cke_o(cke), .cke_oe_o(cke_oe), .cs_oe_o(cs_oe));

  dram_ranks_model #(.CLOSE_CYCLES(5)) dram_ranks_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .arrive_i(arrive), .precharge_i(pre),
    .pages_open_o(pages));

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Classic single cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rd;
    {cyc, stb} <= 2'b00;
  endtask

  // One-cycle pulse on {refresh request, refresh done, arrivals}
  task automatic pulse(input logic [5:0] m);
    @(posedge clk_i);
    {rreq, rdone, arrive} <= m;
    @(posedge clk_i);
    {rreq, rdone, arrive} <= 6'h00;
  endtask

  function automatic logic [3:0] pick(input int s);
    case (s)
      0: return cke;
      1: return cmd;
      2: return dready;
      3: return dll;
      5: return pre;
      default: return {3'b000, rready};
    endcase
  endfunction

  // Counts settled cycles until the chosen output shows the value
  task automatic wait_for(input int s, input logic [3:0] e);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (pick(s) !== e && n < 400);
    check(pick(s), e);
  endtask

  initial
  begin
    #100000;
    errors++;
    report_and_stop;
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(negedge clk_i);
    check(cke, 4'h0);
    check({cke_oe, cs_oe}, 8'hff);
    wb(0, 8'h00, 0);
    check(q, 32'h0);
    wb(0, 8'h08, 0);
    check(q, 32'hf);
    wb(1, 8'h10, 32'hffff);
    wb(0, 8'h10, 0);
    check(q, 32'h0);
    wb(1, 8'h00, 32'h6080);
    wb(0, 8'h00, 0);
    check(q, 32'h6080);
    $display("test reset_regs done");
    wb(1, 8'h00, 32'h2000 | T);
    wb(1, 8'h04, 32'h1);
    wait_for(0, 4'hf);
    wait_for(0, 4'h0);
    pulse(6'h01);
    wait_for(0, 4'h1);
    check(n, 1);
    wait_for(1, 4'h1);
    check(n, 2);
    pulse(6'h01);
    wait_for(0, 4'h0);
    check(n, T + 2);
    check({pages, pre}, 8'h10);
    $display("test active_sleep done");
    wb(1, 8'h00, 32'h6000 | T);
    pulse(6'h01);
    wait_for(5, 4'h1);
    check(pages[0], 1'b1);
    wait_for(3, 4'h1);
    check({cke[0], pages[0]}, 2'b00);
    pulse(6'h01);
    wait_for(1, 4'h1);
    check(n, 3);
    wait_for(2, 4'h1);
    check(n, 2);
    $display("test dll_off_sleep done");
    pulse(6'h20);
    wait_for(4, 4'h1);
    check(cke, 4'hf);
    pulse(6'h10);
    wait_for(0, 4'h0);
    check(rready, 1'b0);
    $display("test refresh done");
    @(posedge clk_i) queued <= 4'h2;
    wait_for(0, 4'h2);
    repeat (3 * T) @(negedge clk_i);
    check(cke, 4'h2);
    @(posedge clk_i) queued <= 4'h0;
    wait_for(0, 4'h0);
    check(n, 2);
    $display("test queued_hold done");
    wb(1, 8'h00, 32'h0000 | T);
    pulse(6'h0f);
    wait_for(0, 4'hf);
    repeat (3 * T) @(negedge clk_i);
    check(cke, 4'hf);
    wb(0, 8'h0c, 0);
    check(q, 32'h0000_0f0f);
    $display("test no_sleep done");
    wb(1, 8'h04, 32'h5);
    wb(1, 8'h00, 32'h6080);
    wb(0, 8'h00, 0);
    check(q, 32'h0000 | T);
    wb(1, 8'h08, 32'h5);
    repeat (2) @(negedge clk_i);
    check({cke_oe, cs_oe}, 8'hff);
    wb(1, 8'h04, 32'h7);
    repeat (2) @(negedge clk_i);
    check({cke_oe, cs_oe}, 8'h55);
    $display("test lock_tristate done");
    report_and_stop;
  end
endmodule // dram_rank_cke_powerdown_tb

//--- tb/dram_ranks_model.sv
// Behavioural rank array: pages open on access and close some cycles after precharge
module dram_ranks_model #(
  parameter int CLOSE_CYCLES = 3
)
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Controller side
  input  wire logic [3:0] arrive_i,
  input  wire logic [3:0] precharge_i,
  output logic      [3:0] pages_open_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [4];
  always_ff @(posedge clk_i)
    for (int i = 0; i < 4; i++)
      if (rst_i || arrive_i[i])
      begin
        pages_open_o[i] <= !rst_i;
        cnt[i] <= 0;
      end
      else if (precharge_i[i] && pages_open_o[i])
      begin
        cnt[i] <= cnt[i] + 1;
        if (cnt[i] == CLOSE_CYCLES - 1)
          pages_open_o[i] <= 1'b0;
      end
endmodule // dram_ranks_model

//--- verilog/dram_pd_regs.sv
// Classic Wishbone register slave of the rank power-down block
`include "dram_pd_cfg.svh"
module dram_pd_regs
  import dram_pd_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Register contents and block state
  input  wire logic [31:0]           status_i,
  output logic      [15:0]           config_o,
  output logic                       cke_en_o,
  output logic                       tri_en_o,
  output logic      [`PDC_RANKS-1:0] present_o
);
  regs_t r;
  regs_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !r.ack)
    begin
      next_r.ack = 1'b1;
      case ({wb_adr_i[7:2], 2'b00})
        `PDC_ADR_CONFIG:  next_r.rdata = {16'h0000, r.config_word};
        `PDC_ADR_CONTROL: next_r.rdata = {29'h0, r.lock, r.tri_en, r.cke_en};
        `PDC_ADR_PRESENT: next_r.rdata = {28'h0, r.present};
        `PDC_ADR_STATUS:  next_r.rdata = status_i;
        default:          next_r.rdata = 32'h0000_0000;
      endcase
    end
    // Writes land at the edge at which the master samples ack high
    if (wb_cyc_i && wb_stb_i && wb_we_i && r.ack)
    begin
      case ({wb_adr_i[7:2], 2'b00})
        `PDC_ADR_CONFIG:
        begin
          if (!r.lock)
          begin
            if (wb_sel_i[0]) next_r.config_word[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) next_r.config_word[15:8] = wb_dat_i[15:8];
          end
        end
        `PDC_ADR_CONTROL:
        begin
          if (wb_sel_i[0])
          begin
            next_r.cke_en = wb_dat_i[`PDC_CTL_CKE_EN];
            next_r.tri_en = wb_dat_i[`PDC_CTL_TRI_EN];
            next_r.lock   = r.lock | wb_dat_i[`PDC_CTL_LOCK];
          end
        end
        `PDC_ADR_PRESENT:
        begin
          if (wb_sel_i[0]) next_r.present = wb_dat_i[`PDC_RANKS-1:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r             <= '0;
      r.config_word <= `PDC_CONFIG_RESET;
      r.present     <= `PDC_PRESENT_RESET;
    end
    else
      r <= next_r;
  end

  assign wb_dat_o  = r.rdata;
  assign wb_ack_o  = r.ack;
  assign config_o  = r.config_word;
  assign cke_en_o  = r.cke_en;
  assign tri_en_o  = r.tri_en;
  assign present_o = r.present;
endmodule // dram_pd_regs

//--- verilog/dram_rank_cke_powerdown.sv
// Per-rank clock-enable power-down control with output tri-state for empty ranks
//
// Implementation choices: the address map and the Wishbone slave port.
`include "dram_pd_cfg.svh"
// Operation
// - Tri-state memory outputs toward connectors that hold no memory devices.
// - An unpopulated rank gets neither chip select nor clock enable driven.
// - After reset all ranks count as populated; tri-state only once software enables.
// - Four independent clock-enable outputs carry the power-save operations.
// - Power-down type comes from config bits 15:12.
// - Idle threshold sits in config bits 11:0, counted in memory clocks.
// - No-power-down type never drops clock enable for idle saving.
// - Active power-down drops clock enable with pages open; exit waits tXP.
// - DLL-off power-down: DLL off, tXP before commands, tXPDLL before data.
// - Every rank has its own idle counter and clock-enable decision.
// - Idle counter restarts at each arrival and counts while the rank idles.
// - At threshold with nothing queued the rank may enter the selected power-down.
// - Config stays writable at run time until the lock is set.
// - Clock enables stay low through reset until software enables them.
// - Wake all ranks before refresh; let them sleep again after it.
// - Close all open pages before precharge power-down drops clock enable.
module dram_rank_cke_powerdown
  import dram_pd_pkg::*;
#(
  parameter int unsigned TXP_CYCLES    = `PDC_TXP_CYCLES,
  parameter int unsigned TXPDLL_CYCLES = `PDC_TXPDLL_CYCLES
)
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Scheduler side, one bit per rank
  input  wire logic [`PDC_RANKS-1:0] txn_arrive_i,
  input  wire logic [`PDC_RANKS-1:0] txn_queued_i,
  input  wire logic [`PDC_RANKS-1:0] pages_open_i,
  output logic      [`PDC_RANKS-1:0] precharge_req_o,
  output logic      [`PDC_RANKS-1:0] cmd_ready_o,
  output logic      [`PDC_RANKS-1:0] data_ready_o,
  output logic      [`PDC_RANKS-1:0] dll_off_o,
  // Refresh handshake
  input  wire logic                  refresh_req_i,
  input  wire logic                  refresh_done_i,
  output logic                       refresh_ready_o,
  // Memory pins, one bit per rank
  output logic      [`PDC_RANKS-1:0] cke_o,
  output logic      [`PDC_RANKS-1:0] cke_oe_o,
  output logic      [`PDC_RANKS-1:0] cs_oe_o
);
  localparam logic [`PDC_EXIT_W-1:0] TXP_CNT    = `PDC_EXIT_W'(TXP_CYCLES);
  localparam logic [`PDC_EXIT_W-1:0] TXPDLL_CNT = `PDC_EXIT_W'(TXPDLL_CYCLES);

  pd_state_t                 s;
  pd_state_t                 next_s;
  logic [15:0]               config_word;
  logic                      cke_en;
  logic                      tri_en;
  logic [`PDC_RANKS-1:0]     present;
  logic [3:0]                pd_type;
  logic [`PDC_IDLE_W-1:0]    idle_threshold;
  logic [31:0]               status_word;
  logic [`PDC_RANKS-1:0]     rank_cke;
  logic [`PDC_RANKS-1:0]     rank_asleep;
  logic [`PDC_RANKS-1:0]     rank_cmd_ready;

  assign pd_type        = config_word[`PDC_TYPE_MSB:`PDC_TYPE_LSB];
  assign idle_threshold = config_word[`PDC_IDLE_MSB:`PDC_IDLE_LSB];

  // Register slave
  dram_pd_regs dram_pd_regs_i
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_adr_i  (wb_adr_i),
    .wb_sel_i  (wb_sel_i),
    .wb_dat_i  (wb_dat_i),
    .wb_dat_o  (wb_dat_o),
    .wb_ack_o  (wb_ack_o),
    .status_i  (status_word),
    .config_o  (config_word),
    .cke_en_o  (cke_en),
    .tri_en_o  (tri_en),
    .present_o (present)
  );

  // Views of the rank states for the status word and the cke and command outputs
  always_comb
  begin
    for (int i = 0; i < `PDC_RANKS; i++)
    begin
      rank_cke[i]       = s.ranks[i].cke;
      rank_asleep[i]    = (s.ranks[i].state == RANK_ASLEEP);
      rank_cmd_ready[i] = s.ranks[i].cmd_ready;
    end
  end

  assign status_word = {19'h0, s.refresh_pending, rank_cmd_ready, rank_asleep, rank_cke};

  // One step of a single rank; every rank runs its own copy
  function automatic rank_t step_rank
  (
    input rank_t                  cur,
    input logic                   en,
    input logic [3:0]             ptype,
    input logic [`PDC_IDLE_W-1:0] thr,
    input logic                   arrive,
    input logic                   queued,
    input logic                   open_pages,
    input logic                   hold
  );
    rank_t                  n;
    logic                   expired;
    logic                   wake;
    logic                   sleeps;
    logic                   ppd;
    logic [`PDC_EXIT_W-1:0] cnt;
    n       = cur;
    expired = (cur.idle >= thr);
    wake    = arrive | queued | hold;
    ppd     = (ptype == `PDC_TYPE_PRECHARGED_DLL_OFF_SLEEP);
    sleeps  = ppd || (ptype == `PDC_TYPE_ACTIVE);
    cnt     = cur.exit_cnt + `PDC_EXIT_W'(1);
    if (arrive)
      n.idle = '0;
    else if (!expired)
      n.idle = cur.idle + `PDC_IDLE_W'(1);
    case (cur.state)
      RANK_OFF:
      begin
        n.cke        = 1'b0;
        n.cmd_ready  = 1'b0;
        n.data_ready = 1'b0;
        if (en)
        begin
          n.state    = RANK_EXIT;
          n.cke      = 1'b1;
          n.exit_cnt = '0;
          n.dll_off  = 1'b0;
          n.woke_txn = 1'b1;
        end
      end
      RANK_AWAKE:
      begin
        if (expired && !wake && sleeps)
        begin
          if (ppd && open_pages)
          begin
            n.state         = RANK_CLOSING;
            n.precharge_req = 1'b1;
          end
          else
          begin
            n.state      = RANK_ASLEEP;
            n.cke        = 1'b0;
            n.dll_off    = ppd;
            n.cmd_ready  = 1'b0;
            n.data_ready = 1'b0;
          end
        end
      end
      RANK_CLOSING:
      begin
        if (wake)
        begin
          n.state         = RANK_AWAKE;
          n.precharge_req = 1'b0;
        end
        else if (!open_pages)
        begin
          n.state         = RANK_ASLEEP;
          n.precharge_req = 1'b0;
          n.cke           = 1'b0;
          n.dll_off       = 1'b1;
          n.cmd_ready     = 1'b0;
          n.data_ready    = 1'b0;
        end
      end
      RANK_ASLEEP:
      begin
        if (wake)
        begin
          n.state    = RANK_EXIT;
          n.cke      = 1'b1;
          n.exit_cnt = '0;
          n.woke_txn = arrive | queued;
        end
      end
      RANK_EXIT:
      begin
        n.exit_cnt = cnt;
        if (arrive || queued)
          n.woke_txn = 1'b1;
        if (cnt >= TXP_CNT)
          n.cmd_ready = 1'b1;
        if (cnt >= (cur.dll_off ? TXPDLL_CNT : TXP_CNT))
        begin
          n.state      = RANK_AWAKE;
          n.cmd_ready  = 1'b1;
          n.data_ready = 1'b1;
          n.dll_off    = 1'b0;
          n.idle       = (cur.woke_txn || arrive || queued) ? '0 : thr;
        end
      end
      default:
      begin
        n = '0;
      end
    endcase
    if (!en)
      n = '0;
    return n;
  endfunction

  always_comb
  begin
    logic all_up;
    all_up = 1'b1;
    next_s = s;
    for (int i = 0; i < `PDC_RANKS; i++)
    begin
      next_s.ranks[i] = step_rank(s.ranks[i], cke_en, pd_type, idle_threshold,
                                  txn_arrive_i[i], txn_queued_i[i], pages_open_i[i],
                                  s.refresh_pending);
      if (s.ranks[i].state != RANK_AWAKE && s.ranks[i].state != RANK_OFF)
        all_up = 1'b0;
      next_s.drive_oe[i] = !(tri_en && !present[i]);
      next_s.deep_sleep[i] = next_s.ranks[i].dll_off
                             && (next_s.ranks[i].state == RANK_ASLEEP);
    end
    if (refresh_req_i)
      next_s.refresh_pending = 1'b1;
    else if (refresh_done_i)
      next_s.refresh_pending = 1'b0;
    next_s.refresh_ready = s.refresh_pending && all_up && !refresh_done_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s          <= '0;
      s.drive_oe <= '1;
    end
    else
      s <= next_s;
  end

  // Pin and scheduler outputs straight from the state flops
  always_comb
  begin
    for (int i = 0; i < `PDC_RANKS; i++)
    begin
      precharge_req_o[i] = s.ranks[i].precharge_req;
      data_ready_o[i]    = s.ranks[i].data_ready;
      dll_off_o[i]       = s.deep_sleep[i];
    end
  end

  assign cmd_ready_o     = rank_cmd_ready;
  assign cke_o           = rank_cke;
  assign cke_oe_o        = s.drive_oe;
  assign cs_oe_o         = s.drive_oe;
  assign refresh_ready_o = s.refresh_ready;
endmodule // dram_rank_cke_powerdown
